// ---- inc/lowpow_pkg.sv ----
package lowpow_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_STATUS  = 8'h04;
    localparam logic [7:0] OFF_IRQ_ST  = 8'h08;
    localparam logic [7:0] OFF_IRQ_MSK = 8'h0C;
    // Control field positions
    localparam int CTRL_STANDBY_REQUEST_N_FLAG = 0;
    localparam int CTRL_MODE_LO   = 1;
    localparam int CTRL_MODE_HI   = 3;
    localparam int CTRL_RAM_ACCESS_ENABLE      = 4;
    // Interrupt status bits
    localparam int EV_WAKE = 0;
    localparam int EV_TRAP = 1;
    localparam int EV_STANDBY_REQUEST_N = 2;
    localparam int NUM_EV  = 3;
    // Reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0010;
    // Bus modes: mode 2 and mode 4 both multiplexed
    localparam logic [2:0] MODE_MUX_A = 3'h2;
    localparam logic [2:0] MODE_MUX_B = 3'h4;
    // Trap window on instruction fetches
    localparam logic [15:0] TRAP_LO   = 16'h0000;
    localparam logic [15:0] TRAP_HI   = 16'h001F;
    localparam logic [15:0] TRAP_VEC  = 16'hFFEE;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Bus-phase clock divides system clock by this count
    localparam int PHASE_DIV = 4;
endpackage

// ---- rtl/lowpow_ctrl.sv ----
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module lowpow_ctrl
    import lowpow_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Pins from outside
    input  wire logic        standby_request_n,
    input  wire logic        hard_init_n,
    // Core side
    input  wire logic        sleep_instruction,
    input  wire logic        irq_request,
    input  wire logic        core_irq_mask,
    input  wire logic        fetch_valid,
    input  wire logic [15:0] fetch_addr,
    input  wire logic        opcode_undefined,
    output logic             core_clk_en,
    output logic             periph_clk_en,
    output logic             osc_en,
    output logic             core_reset,
    output logic             wake_to_service,
    output logic             wake_resume,
    output logic             trap_take,
    output logic [15:0]      trap_vector,
    output logic             ram_access_enable,
    // Pin control
    input  wire logic [7:0]  port_low_live,
    input  wire logic [4:0]  port2_live,
    output logic [4:0]       port2_out,
    output logic             port2_oe,
    output logic [7:0]       port_low_out,
    output logic             port_low_oe,
    output logic [7:0]       addr_hi_out,
    output logic             addr_hi_oe,
    output logic             data_oe,
    output logic [7:0]       data_out,
    output logic             rw_out,
    output logic             rw_oe,
    output logic             address_strobe,
    output logic             address_strobe_oe,
    output logic             crystal_output,
    output logic             irq
);

    typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_STANDBY_REQUEST_N, ST_RESET} pmode_e;

    pmode_e      state_reg;
    logic [1:0]  standby_request_n_sync_reg;
    logic [1:0]  init_sync_reg;
    logic [31:0] ctrl_reg;
    logic [NUM_EV-1:0] ist_reg;
    logic [NUM_EV-1:0] imsk_reg;
    logic [1:0]  phase_reg;
    logic [4:0]  port2_hold_reg;
    logic [7:0]  port_low_hold_reg;
    logic        aw_reg;
    logic        w_reg;
    logic [7:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        trap_reg;
    logic        wake_svc_reg;
    logic        wake_res_reg;

    logic        standby_request_n_n;
    logic        init_n;
    logic        mux_mode;
    logic        phase_low;
    logic        wr_fire;
    logic        wr_ok;
    logic [NUM_EV-1:0] ev_set;
    logic [NUM_EV-1:0] ev_clr;

    // Register window decode, used by both channels
    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == OFF_CTRL) || (a == OFF_STATUS) ||
                  (a == OFF_IRQ_ST) || (a == OFF_IRQ_MSK);
    endfunction

    // Trap address window; caller qualifies with fetch strobe
    function automatic logic in_trap_window(input logic [15:0] a);
        in_trap_window = (a >= TRAP_LO) && (a <= TRAP_HI);
    endfunction

    // Pins are asynchronous to aclk; two flops before use
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            standby_request_n_sync_reg <= 2'h3;
            init_sync_reg <= 2'h3;
        end
        else
        begin
            standby_request_n_sync_reg <= {standby_request_n_sync_reg[0], standby_request_n};
            init_sync_reg <= {init_sync_reg[0], hard_init_n};
        end
    end
    assign standby_request_n_n = standby_request_n_sync_reg[1];
    assign init_n = init_sync_reg[1];

    // Modes two and four both select the multiplexed bus
    assign mux_mode = (ctrl_reg[CTRL_MODE_HI:CTRL_MODE_LO] == MODE_MUX_A) ||
                      (ctrl_reg[CTRL_MODE_HI:CTRL_MODE_LO] == MODE_MUX_B);

    // Power state machine; standby outranks reset outranks wake
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_reg <= ST_RESET;
        else
        begin
            case (state_reg)
                ST_RUN:
                begin
                    if (!standby_request_n_n)
                        state_reg <= ST_STANDBY_REQUEST_N;
                    else if (!init_n)
                        state_reg <= ST_RESET;
                    else if (sleep_instruction)
                        state_reg <= ST_SLEEP;
                end
                ST_SLEEP:
                begin
                    if (!standby_request_n_n)
                        state_reg <= ST_STANDBY_REQUEST_N;
                    else if (!init_n)
                        state_reg <= ST_RESET;
                    else if (irq_request)
                        state_reg <= ST_RUN;
                end
                ST_STANDBY_REQUEST_N:
                begin
                    // Only a reset start leaves standby
                    if (standby_request_n_n && !init_n)
                        state_reg <= ST_RESET;
                end
                ST_RESET:
                begin
                    if (!standby_request_n_n)
                        state_reg <= ST_STANDBY_REQUEST_N;
                    else if (init_n)
                        state_reg <= ST_RUN;
                end
                default:
                    state_reg <= ST_RESET;
            endcase
        end
    end

    // Wake pulses: service entry when unmasked, resume when masked
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wake_svc_reg <= 1'b0;
            wake_res_reg <= 1'b0;
        end
        else
        begin
            wake_svc_reg <= (state_reg == ST_SLEEP) && standby_request_n_n && init_n && irq_request &&
                            !core_irq_mask;
            wake_res_reg <= (state_reg == ST_SLEEP) && standby_request_n_n && init_n && irq_request &&
                            core_irq_mask;
        end
    end
    assign wake_to_service = wake_svc_reg;
    assign wake_resume     = wake_res_reg;

    // Clock gates; peripherals run unless in standby
    assign core_clk_en   = (state_reg == ST_RUN);
    assign periph_clk_en = (state_reg != ST_STANDBY_REQUEST_N);
    assign osc_en        = (state_reg != ST_STANDBY_REQUEST_N);
    assign core_reset    = (state_reg == ST_STANDBY_REQUEST_N) || (state_reg == ST_RESET);

    // Trap on undefined opcode or register-area fetch, fetch cycles only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            trap_reg <= 1'b0;
        else
            trap_reg <= (state_reg == ST_RUN) && fetch_valid &&
                        (opcode_undefined || in_trap_window(fetch_addr));
    end
    assign trap_take   = trap_reg;
    assign trap_vector = TRAP_VEC;

    // Bus-phase clock, a quarter of the system rate
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            phase_reg <= 2'h0;
        else
            phase_reg <= phase_reg + 2'h1;
    end
    assign phase_low = (phase_reg < 2'(PHASE_DIV / 2));

    // Capture pin levels while running so sleep can replay port 2 in every mode and the low port in mux modes only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            port2_hold_reg    <= 5'h00;
            port_low_hold_reg <= 8'h00;
        end
        else if (state_reg == ST_RUN)
        begin
            port2_hold_reg    <= port2_live;
            port_low_hold_reg <= port_low_live;
        end
    end

    // Pin conditions per power state and bus mode
    always_comb
    begin
        port2_out         = port2_hold_reg;
        port2_oe          = 1'b0;
        port_low_out      = port_low_hold_reg;
        port_low_oe       = 1'b0;
        addr_hi_out       = 8'hFF;
        addr_hi_oe        = 1'b0;
        data_out          = 8'hFF;
        data_oe           = 1'b0;
        rw_out            = 1'b1;
        rw_oe             = 1'b0;
        address_strobe    = 1'b0;
        address_strobe_oe = 1'b0;
        crystal_output    = 1'b1;
        case (state_reg)
            ST_SLEEP:
            begin
                port2_oe = 1'b1;
                addr_hi_oe = 1'b1;
                rw_oe = 1'b1;
                if (mux_mode)
                begin
                    port_low_oe = 1'b1;
                    data_oe = phase_low;
                    address_strobe_oe = 1'b1;
                    address_strobe = phase_low;
                end
                else
                begin
                    port_low_out = 8'hFF;
                    port_low_oe = 1'b1;
                end
            end
            ST_RESET:
            begin
                rw_oe = 1'b1;
                address_strobe_oe = 1'b1;
                address_strobe = phase_low;
                if (mux_mode)
                    data_oe = phase_low;
            end
            ST_STANDBY_REQUEST_N:
                crystal_output = 1'b1;
            ST_RUN:
            begin
                port2_out = port2_live;
                port_low_out = port_low_live;
            end
            default:
                crystal_output = 1'b1;
        endcase
    end

    // AXI write path: address and data accepted in either order
    assign s_axi_awready = !aw_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_reg && !s_axi_bvalid;
    assign wr_fire = aw_reg && w_reg && !s_axi_bvalid;
    assign wr_ok   = reg_hit(awaddr_reg);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_reg <= 1'b0;
            w_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_reg <= 1'b0;
                w_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Control register: mode, RAM enable, standby flag.
    // The flag is cleared only by the bus reset or a CTRL write, never by the pins,
    // so software can see that power was held through standby.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ctrl_reg <= CTRL_RESET;
        else if (wr_fire && awaddr_reg == OFF_CTRL && wstrb_reg[0])
            ctrl_reg <= {24'h000000, 3'h0, wdata_reg[4:0]};
    end
    assign ram_access_enable = ctrl_reg[CTRL_RAM_ACCESS_ENABLE] && (state_reg != ST_STANDBY_REQUEST_N);

    // Interrupt events and write-one-to-clear; set beats clear
    assign ev_set[EV_WAKE] = wake_svc_reg || wake_res_reg;
    assign ev_set[EV_TRAP] = trap_reg;
    assign ev_set[EV_STANDBY_REQUEST_N] = (state_reg == ST_STANDBY_REQUEST_N);
    assign ev_clr = (wr_fire && awaddr_reg == OFF_IRQ_ST && wstrb_reg[0]) ?
                    wdata_reg[NUM_EV-1:0] : '0;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_EV; gi++)
        begin : g_ev
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    ist_reg[gi] <= 1'b0;
                else if (ev_set[gi])
                    ist_reg[gi] <= 1'b1;
                else if (ev_clr[gi])
                    ist_reg[gi] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            imsk_reg <= '0;
        else if (wr_fire && awaddr_reg == OFF_IRQ_MSK && wstrb_reg[0])
            imsk_reg <= wdata_reg[NUM_EV-1:0];
    end
    assign irq = |(ist_reg & imsk_reg);

    // AXI read path, one cycle answer
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr)
                OFF_CTRL:    s_axi_rdata <= ctrl_reg;
                OFF_STATUS:  s_axi_rdata <= {29'h0, mux_mode, 2'(state_reg)};
                OFF_IRQ_ST:  s_axi_rdata <= {29'h0, ist_reg};
                OFF_IRQ_MSK: s_axi_rdata <= {29'h0, imsk_reg};
                default:     s_axi_rdata <= 32'h0000_0000;
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // Checks
    property p_sleep_stops_core;
        @(posedge aclk) disable iff (!aresetn)
        (state_reg == ST_SLEEP) |-> !core_clk_en && periph_clk_en;
    endproperty
    a_sleep_stops_core: assert property (p_sleep_stops_core) else $error("core clock live in sleep");

    property p_wake_svc;
        @(posedge aclk) disable iff (!aresetn)
        (state_reg == ST_SLEEP && standby_request_n_n && init_n && irq_request && !core_irq_mask)
            |=> wake_to_service && state_reg == ST_RUN;
    endproperty
    a_wake_svc: assert property (p_wake_svc) else $error("unmasked wake missed");

    property p_wake_res;
        @(posedge aclk) disable iff (!aresetn)
        (state_reg == ST_SLEEP && standby_request_n_n && init_n && irq_request && core_irq_mask)
            |=> wake_resume && !wake_to_service;
    endproperty
    a_wake_res: assert property (p_wake_res) else $error("masked wake wrong");

    property p_no_spurious_wake;
        @(posedge aclk) disable iff (!aresetn)
        (state_reg == ST_SLEEP && !irq_request && standby_request_n_n && init_n) |=> state_reg == ST_SLEEP;
    endproperty
    a_no_spurious_wake: assert property (p_no_spurious_wake) else $error("woke without request");

    property p_standby_request_n_clocks;
        @(posedge aclk) disable iff (!aresetn)
        (state_reg == ST_STANDBY_REQUEST_N) |-> !osc_en && core_reset && crystal_output && !data_oe && !port2_oe;
    endproperty
    a_standby_request_n_clocks: assert property (p_standby_request_n_clocks) else $error("standby not quiet");

    property p_sleep_to_standby_request_n;
        @(posedge aclk) disable iff (!aresetn)
        (state_reg == ST_SLEEP && !standby_request_n_n) |=> state_reg == ST_STANDBY_REQUEST_N;
    endproperty
    a_sleep_to_standby_request_n: assert property (p_sleep_to_standby_request_n) else $error("standby pin ignored in sleep");

    property p_trap_window;
        @(posedge aclk) disable iff (!aresetn)
        (state_reg == ST_RUN && fetch_valid && fetch_addr <= TRAP_HI) |=> trap_take;
    endproperty
    a_trap_window: assert property (p_trap_window) else $error("register fetch not trapped");

    property p_trap_fetch_only;
        @(posedge aclk) disable iff (!aresetn)
        !fetch_valid |=> !trap_take;
    endproperty
    a_trap_fetch_only: assert property (p_trap_fetch_only) else $error("trap without fetch");

    property p_reset_pins;
        @(posedge aclk) disable iff (!aresetn)
        (state_reg == ST_RESET && !mux_mode) |-> rw_oe && rw_out && !addr_hi_oe
            && address_strobe == phase_low;
    endproperty
    a_reset_pins: assert property (p_reset_pins) else $error("reset pin state wrong");

    c_sleep_wake: cover property (@(posedge aclk) state_reg == ST_SLEEP ##1 state_reg == ST_RUN);
    c_standby_request_n_exit: cover property (@(posedge aclk) state_reg == ST_STANDBY_REQUEST_N ##1 state_reg == ST_RESET);
    c_trap: cover property (@(posedge aclk) trap_take);
    c_irq: cover property (@(posedge aclk) irq);

endmodule

// ---- tb/pin_sequencer.sv ----
`timescale 1ns/1ps
// Board logic in front of the standby and reset pins
module pin_sequencer (
    input  wire logic aclk,
    input  wire logic want_standby,
    input  wire logic want_reset,
    output logic      standby_request_n,
    output logic      hard_init_n
);
    logic [3:0] cnt_reg;

    initial
    begin
        standby_request_n = 1'h1;
        hard_init_n       = 1'h1;
        cnt_reg           = 4'h0;
    end

    // Reset drops before standby rises, so the exit is always a reset start
    always @(posedge aclk)
    begin
        if (want_standby)
        begin
            standby_request_n <= 1'h0;
            cnt_reg           <= 4'h0;
        end
        else if (!standby_request_n)
        begin
            hard_init_n <= 1'h0;
            if (!hard_init_n)
                standby_request_n <= 1'h1;
        end
        else if (want_reset)
        begin
            hard_init_n <= 1'h0;
            cnt_reg     <= 4'h0;
        end
        // Reset pulse kept well above the three-cycle minimum
        else if (!hard_init_n)
        begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == 4'h6)
                hard_init_n <= 1'h1;
        end
    end
endmodule

// ---- tb/tb_low_power_and_fetch_trap_control.sv ----
`timescale 1ns/1ps
module tb_low_power_and_fetch_trap_control;
    import lowpow_pkg::*;
    logic        aclk = 1'h0, aresetn = 1'h0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic        standby_request_n, hard_init_n, want_standby = 1'h0, want_reset = 1'h0;
    logic        sleep_instruction = 1'h0, irq_request = 1'h0, core_irq_mask = 1'h0;
    logic        fetch_valid = 1'h0, opcode_undefined = 1'h0;
    logic [15:0] fetch_addr = 16'h0, trap_vector;
    logic [7:0]  port_low_live = 8'h5A, port_low_out, addr_hi_out, data_out;
    logic [4:0]  port2_live = 5'h15, port2_out;
    logic        core_clk_en, periph_clk_en, osc_en, core_reset, wake_to_service, wake_resume;
    logic        trap_take, ram_access_enable, port2_oe, port_low_oe, addr_hi_oe, data_oe;
    logic        rw_out, rw_oe, address_strobe, address_strobe_oe, crystal_output, irq;
    int          bad_count = 0, cmp_count = 0;
    // Fetch cases: expected trap, undefined flag, fetch strobe, address
    localparam logic [18:0] TAB [6] = '{{3'h5, 16'h0000}, {3'h5, 16'h001F}, {3'h1, 16'h0020},
                                        {3'h1, 16'h8000}, {3'h7, 16'h8000}, {3'h0, 16'h0005}};

    always #2.5 aclk = ~aclk;

    pin_sequencer pins (.aclk, .want_standby, .want_reset, .standby_request_n, .hard_init_n);

    lowpow_ctrl uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .standby_request_n, .hard_init_n, .sleep_instruction, .irq_request,
        .core_irq_mask, .fetch_valid, .fetch_addr, .opcode_undefined, .core_clk_en, .periph_clk_en,
        .osc_en, .core_reset, .wake_to_service, .wake_resume, .trap_take, .trap_vector,
        .ram_access_enable, .port_low_live, .port2_live, .port2_out, .port2_oe, .port_low_out,
        .port_low_oe, .addr_hi_out, .addr_hi_oe, .data_oe, .data_out, .rw_out, .rw_oe,
        .address_strobe, .address_strobe_oe, .crystal_output, .irq);

    task automatic finish_test();
        $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // A wait that runs out ends the run at once
    task automatic stall();
        chk(32'h0, 32'h1);
        finish_test();
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic wait_hi(ref logic s, input int lim);
        int n;
        n = 0;
        do
        begin
            @(negedge aclk);
            if (++n > lim) stall();
        end
        while (s !== 1'h1);
    endtask

    // Handshakes judged on values that hold up to the next rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        int   n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        do
        begin
            @(negedge aclk);
            aw = s_axi_awvalid & s_axi_awready;
            w  = s_axi_wvalid & s_axi_wready;
            b  = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'h0;
            if (w) s_axi_wvalid <= 1'h0;
            if (b) s_axi_bready <= 1'h0;
            if (++n > 50) stall();
        end
        while (!b);
    endtask

    task automatic rdr(input logic [7:0] a);
        logic ar, b;
        int   n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        do
        begin
            @(negedge aclk);
            ar = s_axi_arvalid & s_axi_arready;
            b  = s_axi_rvalid;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'h0;
            if (b) s_axi_rready <= 1'h0;
            if (++n > 50) stall();
        end
        while (!b);
    endtask

    task automatic sleep_now();
        @(posedge aclk);
        sleep_instruction <= 1'h1;
        @(posedge aclk);
        sleep_instruction <= 1'h0;
        cyc(2);
    endtask

    task automatic t_regs();
        rdr(OFF_CTRL);
        chk(rd, CTRL_RESET);
        rdr(OFF_STATUS);
        chk(rd, 32'h0);
        rdr(8'h10);
        chk(rd, 32'h0);
        chk({30'h0, rs}, {30'h0, RESP_SLVERR});
        wr(OFF_STATUS, 32'hF);
        rdr(OFF_STATUS);
        chk(rd, 32'h0);
        wr(OFF_IRQ_MSK, 32'h7);
        $display("regs done");
    endtask

    task automatic t_wake_service();
        sleep_now();
        port2_live <= 5'h0A;
        cyc(2);
        chk(core_clk_en, 1'h0);
        chk({periph_clk_en, osc_en}, 2'h3);
        chk({port2_out, port_low_out, addr_hi_out, addr_hi_oe, rw_out, data_oe}, 24'hAFFFFE);
        irq_request <= 1'h1;
        wait_hi(wake_to_service, 10);
        chk(wake_resume, 1'h0);
        irq_request <= 1'h0;
        cyc(2);
        chk({core_clk_en, irq}, 2'h3);
        wr(OFF_IRQ_ST, 32'h1);
        cyc(1);
        chk(irq, 1'h0);
        $display("wake service done");
    endtask

    task automatic t_wake_resume();
        core_irq_mask <= 1'h1;
        sleep_now();
        cyc(20);
        chk(core_clk_en, 1'h0);
        irq_request <= 1'h1;
        wait_hi(wake_resume, 10);
        chk(wake_to_service, 1'h0);
        irq_request   <= 1'h0;
        core_irq_mask <= 1'h0;
        wr(OFF_IRQ_ST, 32'h1);
        $display("wake resume done");
    endtask

    // Trap bit masked first, so the interrupt line must stay low
    task automatic t_trap();
        int n;
        wr(OFF_IRQ_MSK, 32'h5);
        for (int i = 0; i < 6; i++)
        begin
            @(posedge aclk);
            fetch_addr       <= TAB[i][15:0];
            fetch_valid      <= TAB[i][16];
            opcode_undefined <= TAB[i][17];
            @(posedge aclk);
            fetch_valid      <= 1'h0;
            opcode_undefined <= 1'h0;
            n = 0;
            repeat (3) @(negedge aclk) n += int'(trap_take === 1'h1);
            chk(n, TAB[i][18]);
        end
        chk({irq, trap_vector}, {1'h0, TRAP_VEC});
        wr(OFF_IRQ_MSK, 32'h7);
        cyc(1);
        chk(irq, 1'h1);
        wr(OFF_IRQ_ST, 32'h2);
        cyc(1);
        chk(irq, 1'h0);
        $display("trap done");
    endtask

    task automatic t_reset_sleep();
        sleep_now();
        want_reset <= 1'h1;
        @(posedge aclk);
        want_reset <= 1'h0;
        wait_hi(core_reset, 10);
        cyc(1);
        chk({rw_out, rw_oe, addr_hi_oe, data_oe, port2_oe, port_low_oe}, 6'h30);
        wait_hi(core_clk_en, 40);
        $display("reset in sleep done");
    endtask

    task automatic t_standby();
        wr(OFF_CTRL, 32'h11);
        sleep_now();
        want_standby <= 1'h1;
        wait_hi(core_reset, 10);
        cyc(1);
        chk({osc_en, periph_clk_en, core_clk_en, crystal_output, ram_access_enable}, 5'h2);
        chk({port2_oe, port_low_oe, addr_hi_oe, data_oe, rw_oe, address_strobe_oe}, 6'h0);
        want_standby <= 1'h0;
        wait_hi(core_clk_en, 40);
        rdr(OFF_CTRL);
        chk(rd, 32'h11);
        rdr(OFF_IRQ_ST);
        chk({rd[EV_STANDBY_REQUEST_N], irq}, 2'h3);
        wr(OFF_IRQ_ST, 32'h4);
        $display("standby done");
    endtask

    // Mux sleep: ones on the shared lines during half of the bus phase
    task automatic t_modes();
        int hi;
        for (int m = 0; m < 8; m++)
        begin
            wr(OFF_CTRL, 32'h10 | (m << 1));
            rdr(OFF_STATUS);
            chk(rd[2], m == 2 || m == 4);
        end
        wr(OFF_CTRL, 32'h14);
        sleep_now();
        port_low_live <= 8'h00;
        hi = 0;
        repeat (8) @(negedge aclk) hi += int'(data_oe === 1'h1 && data_out === 8'hFF);
        chk(hi, 32'd4);
        chk({port_low_out, address_strobe_oe}, {8'h5A, 1'h1});
        core_irq_mask <= 1'h1;
        irq_request   <= 1'h1;
        wait_hi(wake_resume, 10);
        irq_request <= 1'h0;
        $display("modes done");
    endtask

    initial
    begin
        cyc(2);
        aresetn <= 1'h1;
        wait_hi(core_clk_en, 10);
        t_regs();
        t_wake_service();
        t_wake_resume();
        t_trap();
        t_reset_sleep();
        t_standby();
        t_modes();
        finish_test();
    end
endmodule
